// [common/ipf_defines.vh]
// constants for the interrupt priority field bank
`ifndef IPF_DEFINES_VH
`define IPF_DEFINES_VH

`define IPF_ADDR_W 4
`define IPF_OFS_PRIO_CTRL 4'h0
`define IPF_OFS_REQ_STATUS 4'h1
`define IPF_OFS_LEVEL_VIEW 4'h2
`define IPF_FIELD_W 3
`define IPF_NUM_SRC 4
`define IPF_TMR_LSB 12
`define IPF_CMP_LSB 8
`define IPF_CAP_LSB 4
`define IPF_EXT_LSB 0
`define IPF_IMPL_MASK 16'h7777
`define IPF_RESET_VALUE 16'h4444
`define IPF_FIELD_RESET 3'h4
`define IPF_LEVEL_OFF 3'h0
`define IPF_ZERO16 16'h0000

`endif

// [rtl/ipf_field.v]
// one three-bit priority field and its request gate
`timescale 1ns/1ps
`include "ipf_defines.vh"

module ipf_field (
  input wire clock,
  input wire rst,
  input wire load,
  input wire [2:0] wdata,
  input wire flag,
  input wire enable,
  output reg [2:0] level,
  output reg request
);

  // ----------------------------------------
  // field storage
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= `IPF_FIELD_RESET;
    end else if (load) begin
      level <= wdata;
    end
  end

  // ----------------------------------------
  // gated request, zero level disables
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      request <= 1'b0;
    end else begin
      request <= flag & enable & (level != `IPF_LEVEL_OFF);
    end
  end

endmodule // ipf_field

// [rtl/ipf_bank.v]
// priority field bank with avalon-mm slave
`timescale 1ns/1ps
`include "ipf_defines.vh"

module ipf_bank (
  input wire clock,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [15:0] writedata,
  input wire [1:0] byteenable,
  output reg [15:0] readdata,
  output reg waitrequest,
  input wire [3:0] src_flag,
  input wire [3:0] src_enable,
  output reg [2:0] timer_one_priority,
  output reg [2:0] compare_ch1_priority,
  output reg [2:0] capture_ch1_priority,
  output reg [2:0] ext_line0_priority,
  output reg [3:0] src_request,
  output reg [2:0] top_level,
  output reg [1:0] top_source
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function is_prio;
    input [3:0] a;
    begin
      is_prio = (a == `IPF_OFS_PRIO_CTRL);
    end
  endfunction

  function [2:0] field_at;
    input [15:0] word;
    input integer lsb;
    begin
      field_at = word[lsb +: `IPF_FIELD_W];
    end
  endfunction

  function [15:0] pack_fields;
    input [2:0] f3;
    input [2:0] f2;
    input [2:0] f1;
    input [2:0] f0;
    begin
      pack_fields = {1'b0, f3, 1'b0, f2, 1'b0, f1, 1'b0, f0};
    end
  endfunction

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_ACK = 2'h2;
  reg [1:0] state;
  reg [1:0] next_state;
  // read data is captured when the request is taken
  wire take = (read | write) & (state == ST_IDLE);
  // writes land only at the edge that sees waitrequest low
  wire done = (state == ST_ACK);
  wire wr_prio = done & write & is_prio(address);
  wire [15:0] lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [15:0] merged;
  wire [15:0] field_bits;
  wire [2:0] lv [0:3];
  wire [3:0] req;
  wire [3:0] raw_flag;
  wire [3:0] raw_en;
  reg [3:0] flag_s1, flag_s2, en_s1, en_s2;
  reg [2:0] next_top_level;
  reg [1:0] next_top_source;
  integer k;

  assign field_bits = pack_fields(lv[3], lv[2], lv[1], lv[0]);
  assign merged = ((writedata & lane_mask) | (field_bits & ~lane_mask)) & `IPF_IMPL_MASK;
  assign raw_flag = src_flag;
  assign raw_en = src_enable;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_s1 <= 4'h0;
      flag_s2 <= 4'h0;
      en_s1 <= 4'h0;
      en_s2 <= 4'h0;
    end else begin
      flag_s1 <= raw_flag;
      flag_s2 <= flag_s1;
      en_s1 <= raw_en;
      en_s2 <= en_s1;
    end
  end

  // ----------------------------------------
  // field instances
  // ----------------------------------------
  ipf_field u_ext (.clock(clock), .rst(rst), .load(wr_prio),
    .wdata(field_at(merged, `IPF_EXT_LSB)), .flag(flag_s2[0]), .enable(en_s2[0]),
    .level(lv[0]), .request(req[0]));
  ipf_field u_cap (.clock(clock), .rst(rst), .load(wr_prio),
    .wdata(field_at(merged, `IPF_CAP_LSB)), .flag(flag_s2[1]), .enable(en_s2[1]),
    .level(lv[1]), .request(req[1]));
  ipf_field u_cmp (.clock(clock), .rst(rst), .load(wr_prio),
    .wdata(field_at(merged, `IPF_CMP_LSB)), .flag(flag_s2[2]), .enable(en_s2[2]),
    .level(lv[2]), .request(req[2]));
  ipf_field u_tmr (.clock(clock), .rst(rst), .load(wr_prio),
    .wdata(field_at(merged, `IPF_TMR_LSB)), .flag(flag_s2[3]), .enable(en_s2[3]),
    .level(lv[3]), .request(req[3]));

  // ----------------------------------------
  // highest pending level, ties to lower index
  // ----------------------------------------
  always @* begin
    next_top_level = `IPF_LEVEL_OFF;
    next_top_source = 2'h0;
    for (k = 0; k < `IPF_NUM_SRC; k = k + 1) begin
      if (req[k] && (lv[k] > next_top_level)) begin
        next_top_level = lv[k];
        next_top_source = k[1:0];
      end
    end
  end

  // ----------------------------------------
  // handshake state, one wait state per transfer
  // ----------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (read | write) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      waitrequest <= 1'b1;
    end else begin
      state <= next_state;
      waitrequest <= (next_state != ST_ACK);
    end
  end

  // ----------------------------------------
  // read data, stands until the next read
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata <= `IPF_ZERO16;
    end else if (take & read) begin
      case (address)
        `IPF_OFS_PRIO_CTRL: begin
          readdata <= field_bits;
        end
        `IPF_OFS_REQ_STATUS: begin
          readdata <= {12'h000, req};
        end
        `IPF_OFS_LEVEL_VIEW: begin
          readdata <= {11'h000, top_source, top_level};
        end
        default: begin
          readdata <= `IPF_ZERO16;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registered copies of fields and requests
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_one_priority <= `IPF_FIELD_RESET;
      compare_ch1_priority <= `IPF_FIELD_RESET;
      capture_ch1_priority <= `IPF_FIELD_RESET;
      ext_line0_priority <= `IPF_FIELD_RESET;
      src_request <= 4'h0;
      top_level <= `IPF_LEVEL_OFF;
      top_source <= 2'h0;
    end else begin
      timer_one_priority <= lv[3];
      compare_ch1_priority <= lv[2];
      capture_ch1_priority <= lv[1];
      ext_line0_priority <= lv[0];
      src_request <= req;
      top_level <= next_top_level;
      top_source <= next_top_source;
    end
  end

endmodule // ipf_bank

// [testbench/ipf_bank_sva.sv]
// assertion checker for the priority field bank
`timescale 1ns/1ps
module ipf_bank_sva (
  input wire clock,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [15:0] readdata,
  input wire waitrequest,
  input wire [2:0] timer_one_priority,
  input wire [2:0] compare_ch1_priority,
  input wire [2:0] capture_ch1_priority,
  input wire [2:0] ext_line0_priority,
  input wire [2:0] top_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd0 = read && !waitrequest && address == 4'h0;
  chk_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read) || $past(write))
    else $error("answer without request");
  chk_resv_zero: assert property (rd0 |-> (readdata & 16'h8888) == 16'h0000)
    else $error("reserved bit read as one");
  chk_tmr_field: assert property (rd0 |-> readdata[14:12] == timer_one_priority)
    else $error("timer field mismatch");
  chk_cmp_field: assert property (rd0 |-> readdata[10:8] == compare_ch1_priority)
    else $error("compare field mismatch");
  chk_cap_field: assert property (rd0 |-> readdata[6:4] == capture_ch1_priority)
    else $error("capture field mismatch");
  chk_ext_field: assert property (rd0 |-> readdata[2:0] == ext_line0_priority)
    else $error("external field mismatch");
  chk_reset_four: assert property ($fell(rst) |-> timer_one_priority == 3'h4 &&
    compare_ch1_priority == 3'h4 && capture_ch1_priority == 3'h4 &&
    ext_line0_priority == 3'h4) else $error("reset level not four");
  cover property (rd0);
  cover property (write && !waitrequest);
  cover property (top_level == 3'h7);
endmodule // ipf_bank_sva
bind ipf_bank ipf_bank_sva u_ipf_bank_sva (.clock(clock), .rst(rst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .timer_one_priority(timer_one_priority), .compare_ch1_priority(compare_ch1_priority),
  .capture_ch1_priority(capture_ch1_priority), .ext_line0_priority(ext_line0_priority),
  .top_level(top_level));

// [testbench/test_ipf_bank.sv]
// self-checking bench for the priority field bank
`timescale 1ns/1ps
module test_ipf_bank;
  reg clock = 0;
  reg rst = 1;
  reg [3:0] address = 4'h0;
  reg read = 0;
  reg write = 0;
  reg [15:0] writedata = 16'h0000;
  reg [1:0] byteenable = 2'b11;
  reg [3:0] src_flag = 4'h0;
  reg [3:0] src_enable = 4'h0;
  wire [15:0] readdata;
  wire waitrequest;
  wire [2:0] p_t, p_c, p_i, p_e, top_level;
  wire [3:0] src_request;
  wire [1:0] top_source;
  integer errors = 0;
  integer tests_run = 0;
  integer i;
  reg [2:0] v;
  reg [15:0] d;
  ipf_bank u_ipf_bank (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .src_flag(src_flag), .src_enable(src_enable),
    .timer_one_priority(p_t), .compare_ch1_priority(p_c), .capture_ch1_priority(p_i),
    .ext_line0_priority(p_e), .src_request(src_request), .top_level(top_level),
    .top_source(top_source));
  initial begin
    forever #25 clock = ~clock;
  end
  task end_of_test;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task cmp(input [63:0] nm, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // avalon cycle, entered just after a rising edge
  task bus(input w, input [3:0] a, input [15:0] wd, input [1:0] be);
    integer n;
    begin
      read <= !w;
      write <= w;
      address <= a;
      writedata <= wd;
      byteenable <= be;
      n = 0;
      @(posedge clock);
      while (waitrequest !== 1'b0) begin
        n = n + 1;
        if (n > 20) begin
          errors = errors + 1;
          end_of_test;
        end
        @(posedge clock);
      end
      d = readdata;
      read <= 0;
      write <= 0;
      @(posedge clock);
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    bus(0, 4'h0, 16'h0000, 2'b11);
    cmp("reset", 16'h4444, d);
    bus(1, 4'h0, 16'hffff, 2'b11);
    bus(0, 4'h0, 16'h0000, 2'b11);
    cmp("resv", 16'h7777, d);
    for (i = 0; i < 8; i = i + 1) begin
      v = i;
      bus(1, 4'h0, {1'b1, v, 1'b1, ~v, 1'b1, v + 3'h1, 1'b1, v + 3'h2}, 2'b11);
      bus(0, 4'h0, 16'h0000, 2'b11);
      cmp("read", {1'b0, v, 1'b0, ~v, 1'b0, v + 3'h1, 1'b0, v + 3'h2}, d);
      cmp("ports", {4'h0, v, ~v, v + 3'h1, v + 3'h2}, {4'h0, p_t, p_c, p_i, p_e});
    end
    bus(1, 4'h0, 16'h0000, 2'b01);
    bus(1, 4'hf, 16'h1234, 2'b11);
    bus(0, 4'hf, 16'h0000, 2'b11);
    cmp("unmap", 16'h0000, d);
    bus(0, 4'h0, 16'h0000, 2'b11);
    cmp("lane", 16'h7000, d);
    src_flag <= 4'hf;
    src_enable <= 4'hf;
    repeat (8) @(posedge clock);
    cmp("req", 16'h0008, {12'h000, src_request});
    cmp("top", 16'h001f, {11'h000, top_level, top_source});
    bus(0, 4'h1, 16'h0000, 2'b11);
    cmp("stat", 16'h0008, d);
    bus(0, 4'h2, 16'h0000, 2'b11);
    cmp("view", 16'h001f, d);
    bus(1, 4'h0, 16'h0001, 2'b11);
    repeat (8) @(posedge clock);
    cmp("req1", 16'h0001, {12'h000, src_request});
    cmp("top1", 16'h0004, {11'h000, top_level, top_source});
    bus(0, 4'h1, 16'h0000, 2'b11);
    cmp("stat1", 16'h0001, d);
    bus(0, 4'h2, 16'h0000, 2'b11);
    cmp("view1", 16'h0001, d);
    end_of_test;
  end
endmodule // test_ipf_bank
